// file: rge_map.svh
// constants of the regenerator addressing and forwarding block
// assumes a 20 MHz clock and frames already split into descriptors upstream
//
// Functional notes
// - discard frames whose check sequence failed
// - choose process, forward or ignore per frame
// - only this regenerator relays frames onward
// - online broadcast: process and forward across
// - drop forwarded frame when far segment inactive
// - forwarded frame leaves within 300 ms (age counts only at the buffer head; txMsg_q holds until the peer takes it)
// - central unit address 1, remote address 2
// - both side addresses zero at power-up
// - sync loss zeroes only that side's address
// - address leaves zero only on discovery probe
// - two identical independent side state machines
// - offline to discovery-ready when sync loss clears
// - sync loss zeroes address, returns to offline
// - probe: bump hop, address hop+2, respond, online
// - foreign destination goes to opposite side forwarding
// - forward request sent out unless side offline
// - own or zero destination processed, not forwarded
// - response carries hop, vendor, version, loss flag
// - answer requests arriving from either direction
// - address space covers eight regenerators
// - broadcast address never valid as source
// - sync loss failure after 2.5 s of defect
`ifndef RGE_MAP_SVH
`define RGE_MAP_SVH

//------------------------------------------------------------
// addresses
//------------------------------------------------------------
`define RGE_ADDR_ADJ    4'h0
`define RGE_ADDR_CTU    4'h1
`define RGE_ADDR_RTU    4'h2
`define RGE_ADDR_OFS    4'h2
`define RGE_ADDR_BCAST  4'hF

//------------------------------------------------------------
// sides and small steps
//------------------------------------------------------------
`define RGE_SIDE_NET    0
`define RGE_SIDE_CUS    1
`define RGE_HOP_INC     8'h01
`define RGE_CNT_INC     32'h0000_0001
`define RGE_CNT_ZERO    32'h0000_0000

//------------------------------------------------------------
// timing
//------------------------------------------------------------
`define RGE_CLK_HZ      20000000
`define RGE_MS_PER_S    1000
`define RGE_SYNC_WORD_LOSS_SET_MS 2500
`define RGE_SYNC_WORD_LOSS_CLR_MS 2000
`define RGE_FWD_MAX_MS  300

`endif

// file: rge_pkg.sv
// types shared by the regenerator addressing block and its buffer
// assumes rge_map.svh is on the include path
`include "rge_map.svh"

package rge_pkg;

	//------------------------------------------------------------
	// states and fields
	//------------------------------------------------------------
	typedef enum logic [1:0] {
		RGE_OFFLINE = 2'b00,
		RGE_DISC    = 2'b01,
		RGE_ONLINE  = 2'b10
	} rge_state_e;

	typedef logic [3:0] rge_addr_t;

	// received frame descriptor; tag names the stored information field
	typedef struct packed {
		logic      valid;
		logic      fcsOk;
		logic      probe;
		rge_addr_t src;
		rge_addr_t dst;
		logic [7:0] hop;
		logic [7:0] tag;
	} rge_rx_s;

	// outgoing message, relayed frame or discovery response
	typedef struct packed {
		logic      probe;
		logic      resp;
		rge_addr_t src;
		rge_addr_t dst;
		logic [7:0] hop;
		logic [7:0] tag;
		logic [7:0] vendor;
		logic [7:0] version;
		logic      loswOpp;
	} rge_msg_s;

	typedef struct packed {
		logic      valid;
		rge_addr_t src;
		logic [7:0] tag;
	} rge_proc_s;

	typedef struct packed {
		logic      valid;
		logic [7:0] hop;
	} rge_disc_s;

	// own or adjacent destination
	function automatic logic rge_is_local(input rge_addr_t dst, input rge_addr_t own);
		return (dst == own) || (dst == `RGE_ADDR_ADJ);
	endfunction

endpackage

// file: rge_buf.sv
// two-entry valid/ready buffer in the forwarding path
// assumes both sides on the same clock
module rge_buf #(
	parameter int W = 8
)(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	// drain side
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);
	import rge_pkg::*;

	logic [W-1:0] mem_q [2];
	logic [W-1:0] mem_d [2];
	logic         wrPtr_q, wrPtr_d;
	logic         rdPtr_q, rdPtr_d;
	logic [1:0]   cnt_q, cnt_d;
	logic         push, pop;

	// full and empty come straight from the count register
	assign inReady  = (cnt_q != 2'h2);
	assign outValid = (cnt_q != 2'h0);
	assign outData  = mem_q[rdPtr_q];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// next pointers, count and storage
	always_comb begin
		mem_d   = mem_q;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		cnt_d   = cnt_q;
		if (push) begin
			mem_d[wrPtr_q] = inData;
			wrPtr_d        = ~wrPtr_q;
		end
		if (pop) begin
			rdPtr_d = ~rdPtr_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	// register only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wrPtr_q  <= 1'b0;
			rdPtr_q  <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			mem_q    <= mem_d;
			wrPtr_q  <= wrPtr_d;
			rdPtr_q  <= rdPtr_d;
			cnt_q    <= cnt_d;
		end
	end

endmodule // rge_buf

// file: rge_regen_top.sv
// network layer of a span regenerator: per-side state, addresses, forwarding
// assumes rx descriptors from logic on clk; sync-loss defects arrive from pins
`include "rge_map.svh"

module rge_regen_top #(
	parameter int unsigned SYNC_WORD_LOSS_SET_CYC = `RGE_SYNC_WORD_LOSS_SET_MS * (`RGE_CLK_HZ / `RGE_MS_PER_S),
	parameter int unsigned SYNC_WORD_LOSS_CLR_CYC = `RGE_SYNC_WORD_LOSS_CLR_MS * (`RGE_CLK_HZ / `RGE_MS_PER_S),
	parameter int unsigned FWD_MAX_CYC  = `RGE_FWD_MAX_MS * (`RGE_CLK_HZ / `RGE_MS_PER_S),
	parameter logic [7:0]  VENDOR_ID    = 8'hA5, // arbitrary value
	parameter logic [7:0]  EOC_VERSION  = 8'h01
)(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// sync-word-loss defect pins, index 0 network, 1 customer
	input  wire logic [1:0]                 loswDefectPin,
	// received frames per side
	input  wire rge_pkg::rge_rx_s [1:0]     rxMsg,
	output logic [1:0]                      rxReady,
	// transmitted messages per side
	output rge_pkg::rge_msg_s [1:0]         txMsg_q,
	output logic [1:0]                      txValid_q,
	input  wire logic [1:0]                 txReady,
	// application layer
	output rge_pkg::rge_proc_s [1:0]        procOut_q,
	output rge_pkg::rge_disc_s [1:0]        discOut_q,
	// status
	output rge_pkg::rge_addr_t [1:0]        sideAddr_q,
	output rge_pkg::rge_state_e [1:0]       sideState_q,
	output logic [1:0]                      loswFail_q
);
	import rge_pkg::*;

	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	logic [1:0]        sync1_q, sync2_q;
	logic [1:0][31:0]  setCnt_q, setCnt_d, clrCnt_q, clrCnt_d;
	logic [1:0]        loswFail_d;
	rge_addr_t [1:0]   sideAddr_d;
	rge_state_e [1:0]  sideState_d;
	rge_proc_s [1:0]   procOut_d;
	rge_disc_s [1:0]   discOut_d;
	rge_msg_s [1:0]    resp_q, resp_d, txMsg_d, fwdIn, fwdOut;
	logic [1:0]        respPend_q, respPend_d, respSet, respClr;
	logic [1:0]        txValid_d;
	logic [1:0][31:0]  age_q, age_d;
	logic [1:0]        fwdPush, fwdInReady, fwdOutValid, fwdOutReady;
	logic [1:0]        accept, frameOk;
	logic [7:0]        hopNext;

	//------------------------------------------------------------
	// defect synchroniser and failure filter
	//------------------------------------------------------------

	// two flops; only the second is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 2'b00;
			sync2_q <= 2'b00;
		end else begin
			sync1_q <= loswDefectPin;
			sync2_q <= sync1_q;
		end
	end

	// persistence counters; clearing waits the shortest allowed absence
	always_comb begin
		setCnt_d   = setCnt_q;
		clrCnt_d   = clrCnt_q;
		loswFail_d = loswFail_q;
		for (int s = 0; s < 2; s++) begin
			if (sync2_q[s]) begin
				clrCnt_d[s] = `RGE_CNT_ZERO;
				if (setCnt_q[s] != SYNC_WORD_LOSS_SET_CYC) begin
					setCnt_d[s] = setCnt_q[s] + `RGE_CNT_INC;
				end else begin
					loswFail_d[s] = 1'b1;
				end
			end else begin
				setCnt_d[s] = `RGE_CNT_ZERO;
				if (clrCnt_q[s] != SYNC_WORD_LOSS_CLR_CYC) begin
					clrCnt_d[s] = clrCnt_q[s] + `RGE_CNT_INC;
				end else begin
					loswFail_d[s] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setCnt_q   <= '0;
			clrCnt_q   <= '0;
			loswFail_q <= 2'b00;
		end else begin
			setCnt_q   <= setCnt_d;
			clrCnt_q   <= clrCnt_d;
			loswFail_q <= loswFail_d;
		end
	end

	//------------------------------------------------------------
	// per-side channel machines and frame decisions
	//------------------------------------------------------------

	// stall rx while the far buffer is full or a response waits
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			rxReady[s] = fwdInReady[s ^ 1] & ~respPend_q[s];
			accept[s]  = rxMsg[s].valid & rxReady[s];
		end
	end

	// both sides run the same loop body, sharing no state
	always_comb begin
		sideAddr_d  = sideAddr_q;
		sideState_d = sideState_q;
		procOut_d   = '0;
		discOut_d   = '0;
		resp_d      = resp_q;
		respSet     = 2'b00;
		fwdPush     = 2'b00;
		fwdIn       = '0;
		frameOk     = 2'b00;
		hopNext     = 8'h00;
		for (int s = 0; s < 2; s++) begin
			// bad check sequence or broadcast source dropped
			frameOk[s] = accept[s] & rxMsg[s].fcsOk & (rxMsg[s].src != `RGE_ADDR_BCAST) &
				(sideState_q[s] != RGE_OFFLINE);
			if (frameOk[s]) begin
				if (rxMsg[s].probe) begin
					// hop bump, new address, go online
					hopNext        = rxMsg[s].hop + `RGE_HOP_INC;
					// only a probe or sync loss moves the address
					sideAddr_d[s]  = hopNext[3:0] + `RGE_ADDR_OFS;
					sideState_d[s] = RGE_ONLINE;
					discOut_d[s ^ 1].valid = 1'b1;
					discOut_d[s ^ 1].hop   = hopNext;
					// response back to this side's initiator
					respSet[s]          = 1'b1;
					resp_d[s]           = '0;
					resp_d[s].resp      = 1'b1;
					resp_d[s].src       = hopNext[3:0] + `RGE_ADDR_OFS;
					resp_d[s].dst       = (s == `RGE_SIDE_NET) ? `RGE_ADDR_CTU : `RGE_ADDR_RTU;
					resp_d[s].hop       = hopNext;
					resp_d[s].vendor    = VENDOR_ID;
					resp_d[s].version   = EOC_VERSION;
					resp_d[s].loswOpp   = loswFail_q[s ^ 1];
					fwdPush[s ^ 1]      = 1'b1;
					fwdIn[s ^ 1].probe  = 1'b1;
					fwdIn[s ^ 1].hop    = hopNext;
				end else if ((sideState_q[s] == RGE_ONLINE) && (rxMsg[s].dst == `RGE_ADDR_BCAST)) begin
					// broadcast processed here and passed across
					procOut_d[s].valid = 1'b1;
					procOut_d[s].src   = rxMsg[s].src;
					procOut_d[s].tag   = rxMsg[s].tag;
					fwdPush[s ^ 1]     = 1'b1;
				end else if ((sideState_q[s] == RGE_ONLINE) && rge_is_local(rxMsg[s].dst, sideAddr_q[s])) begin
					procOut_d[s].valid = 1'b1;
					procOut_d[s].src   = rxMsg[s].src;
					procOut_d[s].tag   = rxMsg[s].tag;
				end else if (rxMsg[s].dst != sideAddr_q[s]) begin
					fwdPush[s ^ 1] = 1'b1;
				end
				if (!rxMsg[s].probe) begin
					fwdIn[s ^ 1].src = rxMsg[s].src;
					fwdIn[s ^ 1].dst = rxMsg[s].dst;
					fwdIn[s ^ 1].hop = rxMsg[s].hop;
					fwdIn[s ^ 1].tag = rxMsg[s].tag;
				end
			end
		end
		for (int s = 0; s < 2; s++) begin
			// no relay into an offline side
			if (sideState_q[s] == RGE_OFFLINE) begin
				fwdPush[s] = 1'b0;
			end
			// sync loss overrides this side only
			unique case (sideState_q[s])
				RGE_OFFLINE: begin
					if (!loswFail_q[s]) begin
						sideState_d[s] = RGE_DISC;
					end
				end
				RGE_DISC, RGE_ONLINE: begin
					if (loswFail_q[s]) begin
						sideAddr_d[s]  = `RGE_ADDR_ADJ;
						sideState_d[s] = RGE_OFFLINE;
					end
				end
				default: begin
					sideAddr_d[s]  = `RGE_ADDR_ADJ;
					sideState_d[s] = RGE_OFFLINE;
				end
			endcase
		end
	end

	// reset leaves both addresses at zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sideAddr_q  <= {`RGE_ADDR_ADJ, `RGE_ADDR_ADJ};
			sideState_q <= '{RGE_OFFLINE, RGE_OFFLINE};
			procOut_q   <= '0;
			discOut_q   <= '0;
			resp_q      <= '0;
		end else begin
			sideAddr_q  <= sideAddr_d;
			sideState_q <= sideState_d;
			procOut_q   <= procOut_d;
			discOut_q   <= discOut_d;
			resp_q      <= resp_d;
		end
	end

	//------------------------------------------------------------
	// forwarding buffers and transmit mux
	//------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : gBuf
		rge_buf #(
			.W ($bits(rge_msg_s))
		) uBuf (
			.clk      (clk),
			.rst_n    (rst_n),
			.inValid  (fwdPush[g]),
			.inReady  (fwdInReady[g]),
			.inData   (fwdIn[g]),
			.outValid (fwdOutValid[g]),
			.outReady (fwdOutReady[g]),
			.outData  (fwdOut[g])
		);
	end

	// response first; a stale head is dropped rather than sent late
	always_comb begin
		txValid_d   = txValid_q;
		txMsg_d     = txMsg_q;
		respClr     = 2'b00;
		fwdOutReady = 2'b00;
		age_d       = age_q;
		for (int s = 0; s < 2; s++) begin
			if (txValid_q[s] && txReady[s]) begin
				txValid_d[s] = 1'b0;
			end
			if (!txValid_q[s] || txReady[s]) begin
				if (respPend_q[s]) begin
					txValid_d[s] = 1'b1;
					txMsg_d[s]   = resp_q[s];
					respClr[s]   = 1'b1;
				end else if (fwdOutValid[s] && (sideState_q[s] != RGE_OFFLINE)) begin
					txValid_d[s]   = 1'b1;
					txMsg_d[s]     = fwdOut[s];
					fwdOutReady[s] = 1'b1;
				end
			end
			if (fwdOutValid[s] && !fwdOutReady[s] &&
				((sideState_q[s] == RGE_OFFLINE) || (age_q[s] == FWD_MAX_CYC))) begin
				fwdOutReady[s] = 1'b1;
			end
			age_d[s] = (fwdOutValid[s] && !fwdOutReady[s]) ? (age_q[s] + `RGE_CNT_INC) : `RGE_CNT_ZERO;
		end
		// a fresh response cannot meet its own clear: rx is stalled while one waits
		respPend_d = (respPend_q & ~respClr) | respSet;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txValid_q  <= 2'b00;
			txMsg_q    <= '0;
			respPend_q <= 2'b00;
			age_q      <= '0;
		end else begin
			txValid_q  <= txValid_d;
			txMsg_q    <= txMsg_d;
			respPend_q <= respPend_d;
			age_q      <= age_d;
		end
	end

	//------------------------------------------------------------
	// assertions; sync-loss checks watch the customer side
	//------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_sync_word_loss_zero;
		loswFail_q[1] && (sideState_q[1] != RGE_OFFLINE) |=> (sideAddr_q[1] == `RGE_ADDR_ADJ) && (sideState_q[1] == RGE_OFFLINE);
	endproperty
	a_sync_word_loss_zero: assert property (p_sync_word_loss_zero) else $error("sync loss did not reset side");

	property p_sync_word_loss_other;
		loswFail_q[1] && !loswFail_q[0] && !frameOk[0] |=> $stable(sideAddr_q[0]);
	endproperty
	a_sync_word_loss_other: assert property (p_sync_word_loss_other) else $error("other side address disturbed");

	property p_probe_addr;
		frameOk[0] && rxMsg[0].probe && !loswFail_q[0] |=>
			(sideAddr_q[0] == $past(rxMsg[0].hop[3:0]) + 4'h3) && (sideState_q[0] == RGE_ONLINE);
	endproperty
	a_probe_addr: assert property (p_probe_addr) else $error("probe address wrong");

	property p_probe_disc;
		frameOk[0] && rxMsg[0].probe |=> discOut_q[1].valid && (discOut_q[1].hop == $past(rxMsg[0].hop) + `RGE_HOP_INC);
	endproperty
	a_probe_disc: assert property (p_probe_disc) else $error("discovery message missing");

	property p_resp_out;
		respPend_q[0] && (!txValid_q[0] || txReady[0]) |=>
			txValid_q[0] && txMsg_q[0].resp && (txMsg_q[0].dst == `RGE_ADDR_CTU) && (txMsg_q[0].vendor == VENDOR_ID);
	endproperty
	a_resp_out: assert property (p_resp_out) else $error("discovery response not sent");

	property p_addr_hold;
		!(frameOk[0] && rxMsg[0].probe) && !loswFail_q[0] |=> $stable(sideAddr_q[0]);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved without probe");

	property p_fcs_drop;
		accept[0] && !rxMsg[0].fcsOk |-> !fwdPush[1] ##1 !procOut_q[0].valid && !discOut_q[1].valid;
	endproperty
	a_fcs_drop: assert property (p_fcs_drop) else $error("bad frame used");

	property p_bcast;
		frameOk[0] && !rxMsg[0].probe && (sideState_q[0] == RGE_ONLINE) && (rxMsg[0].dst == `RGE_ADDR_BCAST)
			&& (sideState_q[1] != RGE_OFFLINE) |-> fwdPush[1] ##1 procOut_q[0].valid;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast not processed and forwarded");

	property p_off_nofwd;
		sideState_q[1] == RGE_OFFLINE |-> !fwdPush[1];
	endproperty
	a_off_nofwd: assert property (p_off_nofwd) else $error("relay into offline side");

	property p_offline_exit;
		(sideState_q[0] == RGE_OFFLINE) && !loswFail_q[0] |=> sideState_q[0] == RGE_DISC;
	endproperty
	a_offline_exit: assert property (p_offline_exit) else $error("offline not left");

	property p_age;
		age_q[0] <= FWD_MAX_CYC;
	endproperty
	a_age: assert property (p_age) else $error("forward delay exceeded");

	c_probe: cover property (frameOk[0] && rxMsg[0].probe ##1 respPend_q[0]);
	c_bcast: cover property (frameOk[0] && (rxMsg[0].dst == `RGE_ADDR_BCAST) && fwdPush[1]);
	c_relay: cover property (fwdPush[0] ##[1:4] txValid_q[0] && !txMsg_q[0].resp);
	c_loss:  cover property ((sideState_q[1] == RGE_ONLINE) ##1 loswFail_q[1]);

endmodule // rge_regen_top

// file: rge_peer.sv
// far-side sink model for one transmit side of the regenerator
// assumes txMsg_q and txValid_q come from flops on clk
module rge_peer (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// stall request from the bench
	input  wire logic             stall,
	// link from the regenerator
	input  wire rge_pkg::rge_msg_s msg,
	input  wire logic             valid,
	output logic                  ready,
	// record of accepted messages
	output logic [7:0]            rcvCnt,
	output rge_pkg::rge_msg_s     rcvMsg
);
	timeunit 1ns;
	timeprecision 1ns;
	import rge_pkg::*;

	// no retransmit
	// a terminal end never retries; it only holds off while stalled
	assign ready = !stall;

	// keep the count and the last word, enough for in-order checks
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rcvCnt <= 8'h00;
			rcvMsg <= '0;
		end else if (valid && ready) begin
			rcvCnt <= rcvCnt + 8'h01;
			rcvMsg <= msg;
		end
	end
endmodule // rge_peer

// file: rge_regen_top_tb.sv
// self-checking bench for the regenerator addressing and forwarding block
// assumes rge_pkg, rge_peer and the design are compiled first
module rge_regen_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rge_pkg::*;

	//------------------------------------------------------------
	// signals
	//------------------------------------------------------------
	logic             clk = 1'b0;
	logic             rst_n = 1'b0;
	logic [1:0]       loswDefectPin = 2'b00;
	rge_rx_s [1:0]    rxMsg = '0;
	logic [1:0]       stall = 2'b00;
	logic [1:0]       rxReady, txValid_q, txReady, loswFail_q;
	rge_msg_s [1:0]   txMsg_q;
	rge_msg_s         rcvMsg [2];
	logic [7:0]       rcvCnt [2];
	rge_proc_s [1:0]  procOut_q;
	rge_disc_s [1:0]  discOut_q;
	rge_addr_t [1:0]  sideAddr_q;
	rge_state_e [1:0] sideState_q;
	rge_proc_s        procLast [2];
	rge_disc_s        discLast [2];
	int               procCnt [2];
	int               fails, checksDone, cycles;

	// 20 MHz clock
	always #25 clk = ~clk;

	// short sync-loss and stale counts keep the run brief
	rge_regen_top #(.SYNC_WORD_LOSS_SET_CYC(20), .SYNC_WORD_LOSS_CLR_CYC(10), .FWD_MAX_CYC(8)) dut (
		.clk(clk), .rst_n(rst_n), .loswDefectPin(loswDefectPin), .rxMsg(rxMsg),
		.rxReady(rxReady), .txMsg_q(txMsg_q), .txValid_q(txValid_q), .txReady(txReady),
		.procOut_q(procOut_q), .discOut_q(discOut_q), .sideAddr_q(sideAddr_q),
		.sideState_q(sideState_q), .loswFail_q(loswFail_q));

	for (genvar s = 0; s < 2; s++) begin : g_peer
		rge_peer peer (.clk(clk), .rst_n(rst_n), .stall(stall[s]), .msg(txMsg_q[s]),
			.valid(txValid_q[s]), .ready(txReady[s]), .rcvCnt(rcvCnt[s]), .rcvMsg(rcvMsg[s]));
	end

	// one-cycle pulses are caught here so tests can look back; also the hang guard
	always @(posedge clk) begin
		cycles++;
		for (int s = 0; s < 2; s++) begin
			if (procOut_q[s].valid === 1'b1) begin
				procCnt[s]++;
				procLast[s] = procOut_q[s];
			end
			if (discOut_q[s].valid === 1'b1) discLast[s] = discOut_q[s];
		end
		if (cycles >= 4000) begin
			fails++;
			give_verdict();
		end
	end

	//------------------------------------------------------------
	// tasks
	//------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a response has no tag of ours; only a response carries vendor fields
	task automatic chkMsg(input rge_msg_s got, input rge_msg_s exp);
		rge_msg_s m;
		m = got;
		if (exp.probe || exp.resp) m.tag = exp.tag;
		else m.hop = exp.hop;
		if (!exp.resp) {m.vendor, m.version, m.loswOpp} = {exp.vendor, exp.version, exp.loswOpp};
		checksDone++;
		if (m !== exp) begin
			fails++;
			$display("Error at %0t: message %h expected %h", $time, got, exp);
		end
	endtask

	function automatic rge_msg_s mk(input logic p, input logic r, input rge_addr_t sa,
			input rge_addr_t da, input logic [7:0] h, input logic [7:0] t, input logic lo);
		mk = {p, r, sa, da, h, t, 8'hA5, 8'h01, lo};
	endfunction

	// offer one frame and hold it until the edge that takes it
	task automatic send(input int s, input logic p, input rge_addr_t sa, input rge_addr_t da,
			input logic [7:0] h, input logic [7:0] t, input logic ok);
		int n;
		@(negedge clk);
		rxMsg[s] = {1'b1, ok, p, sa, da, h, t};
		n = 0;
		while (rxReady[s] !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		rxMsg[s] = '0;
		chk(16'(n < 50), 16'h1);
	endtask

	task automatic waitTx(input int s, input logic [7:0] base);
		int n;
		n = 0;
		while (rcvCnt[s] === base && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n < 40), 16'h1);
	endtask

	task automatic waitState(input int s, input rge_state_e st);
		int n;
		n = 0;
		while (sideState_q[s] !== st && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(sideState_q[s], st);
	endtask

	task automatic give_verdict();
		if (fails == 0 && checksDone > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	//------------------------------------------------------------
	// tests
	//------------------------------------------------------------
	initial begin
		rge_addr_t  dstT [6];
		logic [7:0] b0, b1;
		int         p0, n;
		dstT = '{4'h3, 4'h0, 4'h4, 4'hF, 4'h4, 4'h4};
		repeat (2) @(negedge clk);
		chk({8'h00, sideAddr_q}, 16'h0000);
		chk(sideState_q, 16'h0000);
		rst_n = 1'b1;
		waitState(0, RGE_DISC);
		waitState(1, RGE_DISC);
		// probe from the central end: learn address, answer, relay
		b0 = rcvCnt[0];
		b1 = rcvCnt[1];
		send(0, 1'b1, 4'h1, 4'h0, 8'h00, 8'h11, 1'b1);
		waitTx(0, b0);
		chkMsg(rcvMsg[0], mk(1'b0, 1'b1, 4'h3, 4'h1, 8'h01, 8'h00, 1'b0));
		waitTx(1, b1);
		chkMsg(rcvMsg[1], mk(1'b1, 1'b0, 4'h0, 4'h0, 8'h01, 8'h00, 1'b0));
		chk(sideAddr_q[0], 16'h3);
		chk(sideState_q[0], RGE_ONLINE);
		chk(sideAddr_q[1], 16'h0);
		chk(discLast[1].hop, 16'h01);
		// probe from the remote end, two hops away
		b0 = rcvCnt[0];
		b1 = rcvCnt[1];
		send(1, 1'b1, 4'h2, 4'h0, 8'h02, 8'h12, 1'b1);
		waitTx(1, b1);
		chkMsg(rcvMsg[1], mk(1'b0, 1'b1, 4'h5, 4'h2, 8'h03, 8'h00, 1'b0));
		waitTx(0, b0);
		chkMsg(rcvMsg[0], mk(1'b1, 1'b0, 4'h0, 4'h0, 8'h03, 8'h00, 1'b0));
		chk(sideAddr_q[1], 16'h5);
		chk(sideAddr_q[0], 16'h3);
		chk(discLast[0].hop, 16'h03);
		// remote end addresses this unit on its own side
		p0 = procCnt[1];
		send(1, 1'b0, 4'h2, 4'h5, 8'h00, 8'h30, 1'b1);
		repeat (4) @(negedge clk);
		chk(16'(procCnt[1] - p0), 16'h1);
		chk(procLast[1].tag, 16'h30);
		// sorting of ordinary frames: own, adjacent, foreign, broadcast, bad check, bad source
		for (int i = 0; i < 6; i++) begin
			p0 = procCnt[0];
			b1 = rcvCnt[1];
			send(0, 1'b0, (i == 5) ? 4'hF : 4'h1, dstT[i], 8'h00, 8'h20 + 8'(i), i != 4);
			repeat (12) @(negedge clk);
			chk(16'(procCnt[0] - p0), 16'(i < 2 || i == 3));
			chk(16'(rcvCnt[1] - b1), 16'(i == 2 || i == 3));
			if (i == 2 || i == 3) chkMsg(rcvMsg[1], mk(1'b0, 1'b0, 4'h1, dstT[i], 8'h00, 8'h20 + 8'(i), 1'b0));
			if (i < 2) chk(procLast[0].tag, 16'(8'h20 + 8'(i)));
			if (i < 2) chk(procLast[0].src, 16'h1);
		end
		// far side stalls: buffer fills and refuses, then drains in order
		stall[1] = 1'b1;
		b1 = rcvCnt[1];
		for (int i = 0; i < 3; i++) send(0, 1'b0, 4'h1, 4'h4, 8'h00, 8'h40 + 8'(i), 1'b1);
		chk(rxReady[0], 16'h0);
		stall[1] = 1'b0;
		for (int i = 0; i < 3; i++) begin
			waitTx(1, b1 + 8'(i));
			chk(rcvMsg[1].tag, 16'(8'h40 + 8'(i)));
		end
		// far side stalls past the age limit: the waiting head is dropped
		stall[1] = 1'b1;
		b1 = rcvCnt[1];
		send(0, 1'b0, 4'h1, 4'h4, 8'h00, 8'h60, 1'b1);
		send(0, 1'b0, 4'h1, 4'h4, 8'h00, 8'h61, 1'b1);
		repeat (12) @(negedge clk);
		stall[1] = 1'b0;
		repeat (4) @(negedge clk);
		chk(16'(rcvCnt[1] - b1), 16'h1);
		chk(rcvMsg[1].tag, 16'h60);
		// sync loss on the customer side only
		loswDefectPin[1] = 1'b1;
		n = 0;
		while (loswFail_q[1] !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n >= 20 && n < 60), 16'h1);
		repeat (2) @(negedge clk);
		chk(sideAddr_q[1], 16'h0);
		chk(sideState_q[1], RGE_OFFLINE);
		chk(sideAddr_q[0], 16'h3);
		chk(loswFail_q[0], 16'h0);
		b0 = rcvCnt[0];
		b1 = rcvCnt[1];
		send(0, 1'b1, 4'h1, 4'h0, 8'h00, 8'h13, 1'b1);
		waitTx(0, b0);
		chkMsg(rcvMsg[0], mk(1'b0, 1'b1, 4'h3, 4'h1, 8'h01, 8'h00, 1'b1));
		send(0, 1'b0, 4'h1, 4'h4, 8'h00, 8'h50, 1'b1);
		repeat (12) @(negedge clk);
		chk(16'(rcvCnt[1] - b1), 16'h0);
		loswDefectPin[1] = 1'b0;
		waitState(1, RGE_DISC);
		chk(sideAddr_q[1], 16'h0);
		give_verdict();
	end
endmodule // rge_regen_top_tb
